// ===== mbe_capture.sv
// Per-instance error capture: address, data, kind, byte lanes and region
`default_nettype none
module mbe_capture #(
	parameter int INST = 0
) (
	// Clock and reset
	input  wire logic                       sys_clk,
	input  wire logic                       rstn,
	// Error event and firmware release
	input  wire mbe_pkg::mbe_event_t        err_ev,
	input  wire logic                       err_clr,
	input  wire logic [mbe_pkg::RSEL_W-1:0] rsel,
	// Captured record
	output var   mbe_pkg::mbe_capt_t        capt_r
);
	mbe_pkg::mbe_capt_t capt_nxt;
	logic               parity;

	always_comb begin
		capt_nxt = capt_r;
		parity   = (err_ev.kind == mbe_pkg::MBE_APAR) || (err_ev.kind == mbe_pkg::MBE_WPAR);
		if (mbe_pkg::accepts(err_ev, capt_r.valid, err_clr)) begin
			// New error wins over a release in the same cycle
			capt_nxt.valid      = 1'b1; // R10
			capt_nxt.kind       = err_ev.kind; // R10
			capt_nxt.refresh    = err_ev.refresh;
			capt_nxt.addr       = err_ev.addr;
			capt_nxt.data       = err_ev.data; // R2
			capt_nxt.lanes      = (err_ev.kind == mbe_pkg::MBE_WPAR) ? err_ev.lanes : 4'h0; // R9
			capt_nxt.region_reg = 4'h0;
			capt_nxt.region_amb = 1'b0;
			if (INST == mbe_pkg::INST_MST) begin
				capt_nxt.region_mem = err_ev.region;
			end else if (INST >= mbe_pkg::INST_B0 && !parity) begin
				capt_nxt.region_mem = rsel[mbe_pkg::RSEL_BMEM_LO +: mbe_pkg::RGN_W]; // R1
			end else begin
				capt_nxt.region_mem = rsel[mbe_pkg::RSEL_AMEM_LO +: mbe_pkg::RGN_W]; // R7
				if (parity && !err_ev.refresh) begin
					// Memory or register space: hardware cannot tell, both are kept
					capt_nxt.region_reg = rsel[mbe_pkg::RSEL_REG_LO +: mbe_pkg::RGN_W]; // R8
					capt_nxt.region_amb = 1'b1; // R8
				end
			end
		end else if (err_clr) begin
			capt_nxt = '0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			capt_r <= '0;
		end else begin
			capt_r <= capt_nxt; // R11
		end
	end
endmodule : mbe_capture
`default_nettype wire

// ===== mbe_fw_model.sv
// Firmware model: reads a held capture, then releases it after a delay
`default_nettype none
module mbe_fw_model #(
	parameter int FAST = 8,
	parameter int SLOW = 16
) (
	// Clock and reset
	input  wire logic                                        sys_clk,
	input  wire logic                                        rstn,
	// Behaviour control
	input  wire logic                                        auto_en,
	input  wire logic                                        slow,
	// Captures and releases
	input  wire mbe_pkg::mbe_capt_t [mbe_pkg::NUM_INST-1:0] capt,
	output logic [mbe_pkg::NUM_INST-1:0]                     fw_clr
);
	timeunit 1ns;
	timeprecision 100ps;
	// ========================================
	// Release timing
	int age [mbe_pkg::NUM_INST];
	// Release only after the hold time, so the bench reads a stable record
	always @(posedge sys_clk or negedge rstn) begin
		for (int i = 0; i < mbe_pkg::NUM_INST; i++) begin
			if (!rstn) begin
				fw_clr[i] <= 1'b0;
				age[i]    <= 0;
			end else begin
				fw_clr[i] <= 1'b0;
				if (auto_en && capt[i].valid && !fw_clr[i]) begin
					if (age[i] >= (slow ? SLOW : FAST)) begin
						fw_clr[i] <= 1'b1;
						age[i]    <= 0;
					end else begin
						age[i] <= age[i] + 1;
					end
				end else begin
					age[i] <= 0;
				end
			end
		end
	end
endmodule : mbe_fw_model
`default_nettype wire

// ===== mbe_memory_bus_controller.sv
// Memory bus controller error capture: master and four cache module instances
`default_nettype none
// Operation
// R1: Group B nonexistent memory: latch address, region from select bits 12-15.
// R2: Every detected error stores its transfer data word in the capture; an error arriving while a capture is held is dropped unless released in that cycle.
// R3: Port involved in an error goes to master status bits 10-12.
// R4: Report by NMI or interrupt; status bit 14 set only for NMI.
// R5: Master address or write parity error: latch address, region bits 0-3.
// R6: Master write parity error marks failing byte lanes in status bits 0-3.
// R7: Group A refresh parity error: latch address, region from select bits 8-11.
// R8: Group A access parity: region bits 8-11 or 20-23, indistinguishable.
// R9: Group A write parity error marks byte lanes in own status bits 0-3.
// R10: Each instance detects and distinguishes the three error kinds.
// R11: Captured information stays stable until firmware clears the error.
module mbe_memory_bus_controller (
	// Clock and reset
	input  wire logic                                       sys_clk,
	input  wire logic                                       rstn,
	// Error events, one per instance
	input  wire mbe_pkg::mbe_event_t [mbe_pkg::NUM_INST-1:0] err_ev,
	// Firmware release of each capture
	input  wire logic [mbe_pkg::NUM_INST-1:0]               err_clr,
	// Firmware configuration
	input  wire logic                                       rsel_wr,
	input  wire logic [mbe_pkg::RSEL_W-1:0]                 rsel_wdata,
	input  wire logic                                       cfg_nmi_sel,
	// Captures
	output wire  mbe_pkg::mbe_capt_t [mbe_pkg::NUM_INST-1:0] capt,
	// Master registers
	output logic [mbe_pkg::RSEL_W-1:0]                      region_select_reg_r,
	output logic [mbe_pkg::REG_W-1:0]                       controller_ctrl_status_r,
	output logic [mbe_pkg::REG_W-1:0]                       diag_status_r,
	output logic [mbe_pkg::REG_W-1:0]                       error_region_r,
	// Group A status registers
	output logic [mbe_pkg::REG_W-1:0]                       cache_group_a_first_csr_r,
	output logic [mbe_pkg::REG_W-1:0]                       cache_group_a_second_csr_r,
	// Interrupts
	output logic                                            nmi_r,
	output logic                                            controller_interrupt_r
);
	// ========================================
	// Capture instances
	logic [mbe_pkg::NUM_INST-1:0] acc;
	logic                         any_acc;
	logic                         any_held;
	logic                         path_nmi;

	genvar gi;
	generate
		for (gi = 0; gi < mbe_pkg::NUM_INST; gi++) begin : g_inst
			assign acc[gi] = mbe_pkg::accepts(err_ev[gi], capt[gi].valid, err_clr[gi]);
			mbe_capture #(
				.INST(gi)
			) u_capt (
				.sys_clk (sys_clk),
				.rstn    (rstn),
				.err_ev  (err_ev[gi]),
				.err_clr (err_clr[gi]),
				.rsel    (region_select_reg_r),
				.capt_r  (capt[gi])
			);
		end
	endgenerate

	always_comb begin
		any_acc  = |acc;
		any_held = 1'b0;
		for (int i = 0; i < mbe_pkg::NUM_INST; i++) begin
			any_held = any_held | capt[i].valid;
		end
	end

	// ========================================
	// Reporting
	mbe_report u_report (
		.sys_clk     (sys_clk),
		.rstn        (rstn),
		.any_accept  (any_acc),
		.any_held    (any_held),
		.cfg_nmi_sel (cfg_nmi_sel),
		.nmi_r       (nmi_r),
		.irq_r       (controller_interrupt_r),
		.path_nmi_r  (path_nmi)
	);

	// ========================================
	// Region select register
	logic [mbe_pkg::RSEL_W-1:0] rsel_nxt;

	always_comb begin
		rsel_nxt = region_select_reg_r;
		if (rsel_wr) begin
			rsel_nxt = rsel_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			region_select_reg_r <= mbe_pkg::RSEL_RST;
		end else begin
			region_select_reg_r <= rsel_nxt;
		end
	end

	// ========================================
	// Master control/status: byte lanes and port field
	logic [mbe_pkg::REG_W-1:0] csr_nxt;
	logic                      port_held_r;
	logic                      port_held_nxt;

	// Lane decode shared by the master and both group A registers
	function automatic logic [mbe_pkg::LANE_W-1:0] capt_lanes(input mbe_pkg::mbe_event_t ev);
		capt_lanes = (ev.kind == mbe_pkg::MBE_WPAR) ? ev.lanes : 4'h0;
	endfunction : capt_lanes

	always_comb begin
		csr_nxt       = controller_ctrl_status_r;
		port_held_nxt = port_held_r;
		if (acc[mbe_pkg::INST_MST]) begin
			csr_nxt[mbe_pkg::CSR_LANE_LO +: mbe_pkg::LANE_W] =
				capt_lanes(err_ev[mbe_pkg::INST_MST]); // R6
		end
		// First port-carrying error holds the field; lowest instance wins a tie
		if (!port_held_r) begin
			for (int i = mbe_pkg::NUM_INST - 1; i >= 0; i--) begin
				if (acc[i] && err_ev[i].port_vld) begin
					csr_nxt[mbe_pkg::CSR_PORT_LO +: mbe_pkg::PORT_W] = err_ev[i].port; // R3
					port_held_nxt = 1'b1;
				end
			end
		end else if (!any_held && !any_acc) begin
			port_held_nxt = 1'b0; // R11
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			controller_ctrl_status_r <= mbe_pkg::CSR_RST;
			port_held_r              <= 1'b0;
		end else begin
			controller_ctrl_status_r <= csr_nxt;
			port_held_r              <= port_held_nxt;
		end
	end

	// ========================================
	// Diagnostic status: report path flag
	logic [mbe_pkg::REG_W-1:0] dsr_nxt;

	always_comb begin
		dsr_nxt = diag_status_r;
		// Path flag follows the report line one cycle later, through a second register
		dsr_nxt[mbe_pkg::DSR_NMI_BIT] = path_nmi; // R4
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			diag_status_r <= mbe_pkg::DSR_RST;
		end else begin
			diag_status_r <= dsr_nxt;
		end
	end

	// ========================================
	// Master error region
	logic [mbe_pkg::REG_W-1:0] ereg_nxt;
	logic                      mst_par;

	always_comb begin
		ereg_nxt = error_region_r;
		mst_par  = (err_ev[mbe_pkg::INST_MST].kind == mbe_pkg::MBE_APAR) ||
			(err_ev[mbe_pkg::INST_MST].kind == mbe_pkg::MBE_WPAR);
		// Nonexistent-memory errors leave the last parity region in place
		if (acc[mbe_pkg::INST_MST] && mst_par) begin
			ereg_nxt[mbe_pkg::ERR_RGN_LO +: mbe_pkg::RGN_W] =
				err_ev[mbe_pkg::INST_MST].region; // R5
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			error_region_r <= mbe_pkg::ERR_RST;
		end else begin
			error_region_r <= ereg_nxt;
		end
	end

	// ========================================
	// Group A status registers: byte lanes
	logic [mbe_pkg::REG_W-1:0] acsr0_nxt;
	logic [mbe_pkg::REG_W-1:0] acsr1_nxt;

	always_comb begin
		acsr0_nxt = cache_group_a_first_csr_r;
		acsr1_nxt = cache_group_a_second_csr_r;
		if (acc[mbe_pkg::INST_A0]) begin
			acsr0_nxt[mbe_pkg::CSR_LANE_LO +: mbe_pkg::LANE_W] =
				capt_lanes(err_ev[mbe_pkg::INST_A0]); // R9
		end
		if (acc[mbe_pkg::INST_A1]) begin
			acsr1_nxt[mbe_pkg::CSR_LANE_LO +: mbe_pkg::LANE_W] =
				capt_lanes(err_ev[mbe_pkg::INST_A1]); // R9
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cache_group_a_first_csr_r  <= mbe_pkg::CSR_RST;
			cache_group_a_second_csr_r <= mbe_pkg::CSR_RST;
		end else begin
			cache_group_a_first_csr_r  <= acsr0_nxt;
			cache_group_a_second_csr_r <= acsr1_nxt;
		end
	end

	// ========================================
	// Assertions
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	property p_b_nxm_region;
		acc[mbe_pkg::INST_B0] && err_ev[mbe_pkg::INST_B0].kind == mbe_pkg::MBE_NXM |=>
			capt[mbe_pkg::INST_B0].region_mem == $past(region_select_reg_r[15:12]) &&
			capt[mbe_pkg::INST_B0].addr == $past(err_ev[mbe_pkg::INST_B0].addr);
	endproperty
	a_b_nxm_region: assert property (p_b_nxm_region) else $error("B region wrong"); // R1

	property p_data_kept;
		acc[mbe_pkg::INST_A1] |=> capt[mbe_pkg::INST_A1].data == $past(err_ev[mbe_pkg::INST_A1].data);
	endproperty
	a_data_kept: assert property (p_data_kept) else $error("Data not captured"); // R2

	property p_port_field;
		!port_held_r && acc[0] && err_ev[0].port_vld |=>
			controller_ctrl_status_r[12:10] == $past(err_ev[0].port) && port_held_r;
	endproperty
	a_port_field: assert property (p_port_field) else $error("Port field wrong"); // R3

	property p_nmi_path;
		any_acc && cfg_nmi_sel |=> nmi_r ##1 diag_status_r[14];
	endproperty
	a_nmi_path: assert property (p_nmi_path) else $error("NMI path wrong"); // R4

	property p_int_path;
		any_acc && !cfg_nmi_sel |=> controller_interrupt_r ##1 !diag_status_r[14];
	endproperty
	a_int_path: assert property (p_int_path) else $error("Interrupt path wrong"); // R4

	property p_mst_region;
		acc[0] && mst_par |=> error_region_r[3:0] == $past(err_ev[0].region);
	endproperty
	a_mst_region: assert property (p_mst_region) else $error("Master region wrong"); // R5

	property p_mst_lanes;
		acc[0] && err_ev[0].kind == mbe_pkg::MBE_WPAR |=>
			controller_ctrl_status_r[3:0] == $past(err_ev[0].lanes);
	endproperty
	a_mst_lanes: assert property (p_mst_lanes) else $error("Master lanes wrong"); // R6

	property p_a_refresh;
		acc[1] && err_ev[1].refresh && err_ev[1].kind == mbe_pkg::MBE_APAR |=>
			capt[1].region_mem == $past(region_select_reg_r[11:8]) && !capt[1].region_amb;
	endproperty
	a_a_refresh: assert property (p_a_refresh) else $error("Refresh region wrong"); // R7

	property p_a_access;
		acc[1] && !err_ev[1].refresh && err_ev[1].kind == mbe_pkg::MBE_WPAR |=>
			capt[1].region_amb && capt[1].region_reg == $past(region_select_reg_r[23:20]);
	endproperty
	a_a_access: assert property (p_a_access) else $error("Access region wrong"); // R8

	property p_a_lanes;
		acc[1] && err_ev[1].kind == mbe_pkg::MBE_WPAR |=>
			cache_group_a_first_csr_r[3:0] == $past(err_ev[1].lanes);
	endproperty
	a_a_lanes: assert property (p_a_lanes) else $error("Group A lanes wrong"); // R9

	property p_kind;
		acc[4] |=> capt[4].valid && capt[4].kind == $past(err_ev[4].kind);
	endproperty
	a_kind: assert property (p_kind) else $error("Kind not recorded"); // R10

	property p_stable;
		capt[2].valid && !err_clr[2] |=> $stable(capt[2]);
	endproperty
	a_stable: assert property (p_stable) else $error("Capture changed while held"); // R11

	property p_b1_nxm_region;
		acc[mbe_pkg::INST_B1] && err_ev[mbe_pkg::INST_B1].kind == mbe_pkg::MBE_NXM |=>
			capt[mbe_pkg::INST_B1].region_mem ==
			$past(region_select_reg_r[mbe_pkg::RSEL_BMEM_LO +: mbe_pkg::RGN_W]);
	endproperty
	a_b1_nxm_region: assert property (p_b1_nxm_region) else $error("B1 region wrong"); // R1

	property p_mst_data;
		acc[mbe_pkg::INST_MST] |=>
			capt[mbe_pkg::INST_MST].data == $past(err_ev[mbe_pkg::INST_MST].data);
	endproperty
	a_mst_data: assert property (p_mst_data) else $error("Master data not captured"); // R2

	property p_a1_lanes;
		acc[mbe_pkg::INST_A1] && err_ev[mbe_pkg::INST_A1].kind == mbe_pkg::MBE_WPAR |=>
			cache_group_a_second_csr_r[3:0] == $past(err_ev[mbe_pkg::INST_A1].lanes);
	endproperty
	a_a1_lanes: assert property (p_a1_lanes) else $error("Group A second lanes wrong"); // R9

	property p_lines_drop;
		!any_held && !any_acc |=> !nmi_r && !controller_interrupt_r;
	endproperty
	a_lines_drop: assert property (p_lines_drop) else $error("Report line stuck"); // R4

	property p_held_b0;
		capt[mbe_pkg::INST_B0].valid && !err_clr[mbe_pkg::INST_B0] |=>
			$stable(capt[mbe_pkg::INST_B0].addr) && $stable(capt[mbe_pkg::INST_B0].data);
	endproperty
	a_held_b0: assert property (p_held_b0) else $error("B capture changed while held"); // R11

	c_nmi: cover property (any_acc && cfg_nmi_sel ##1 nmi_r);
	c_int: cover property (any_acc && !cfg_nmi_sel ##1 controller_interrupt_r);
	c_release: cover property (capt[0].valid ##1 err_clr[0] ##1 !capt[0].valid);
	c_set_on_clr: cover property (capt[1].valid && err_clr[1] && acc[1]);
	c_refresh: cover property (acc[mbe_pkg::INST_A0] && err_ev[mbe_pkg::INST_A0].refresh);
endmodule : mbe_memory_bus_controller
`default_nettype wire

// ===== mbe_memory_bus_controller_tb.sv
// Self-checking bench for the memory bus error capture block
`default_nettype none
module mbe_memory_bus_controller_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// ========================================
	// Signals
	logic                                        sys_clk = 1'b0;
	logic                                        rstn    = 1'b0;
	mbe_pkg::mbe_event_t [mbe_pkg::NUM_INST-1:0] err_ev  = '0;
	logic [mbe_pkg::NUM_INST-1:0]                tb_clr  = '0;
	logic [mbe_pkg::NUM_INST-1:0]                fw_clr;
	logic [mbe_pkg::NUM_INST-1:0]                err_clr;
	logic                                        rsel_wr = 1'b0;
	logic [mbe_pkg::RSEL_W-1:0]                  rsel_wdata = '0;
	logic                                        nmi_sel = 1'b0;
	logic                                        auto_en = 1'b0;
	logic                                        slow    = 1'b0;
	mbe_pkg::mbe_capt_t [mbe_pkg::NUM_INST-1:0]  capt;
	logic [mbe_pkg::RSEL_W-1:0]                  rsel;
	logic [15:0]                                 controller_ctrl_status, dsr, ereg, acsr0, acsr1;
	logic                                        nmi, irq;
	int                                          err_total = 0;
	int                                          checks_done = 0;
	int                                          seed = 32'hd95a_52ce;
	always #2 sys_clk = ~sys_clk;
	assign err_clr = fw_clr | tb_clr;
	// ========================================
	// Instances
	mbe_memory_bus_controller dut (.sys_clk(sys_clk), .rstn(rstn), .err_ev(err_ev),
		.err_clr(err_clr), .rsel_wr(rsel_wr), .rsel_wdata(rsel_wdata),
		.cfg_nmi_sel(nmi_sel), .capt(capt), .region_select_reg_r(rsel),
		.controller_ctrl_status_r(controller_ctrl_status), .diag_status_r(dsr), .error_region_r(ereg),
		.cache_group_a_first_csr_r(acsr0), .cache_group_a_second_csr_r(acsr1),
		.nmi_r(nmi), .controller_interrupt_r(irq));
	mbe_fw_model fw (.sys_clk(sys_clk), .rstn(rstn), .auto_en(auto_en), .slow(slow),
		.capt(capt), .fw_clr(fw_clr));
	// ========================================
	// Tasks
	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask : tick
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	function automatic mbe_pkg::mbe_event_t rnd(input int k);
		mbe_pkg::mbe_event_t e;
		logic [31:0]         r;
		r         = $random(seed);
		e         = '0;
		e.valid   = 1'b1;
		e.kind    = mbe_pkg::mbe_kind_t'(k);
		e.refresh = r[31];
		e.addr    = r[27:0];
		e.data    = $random(seed);
		r         = $random(seed);
		e.region  = r[7:4];
		e.lanes   = r[3:0];
		e.port_vld = 1'b1;
		e.port    = r[10:8];
		return e;
	endfunction : rnd
	// ========================================
	// Sequence
	initial begin
		mbe_pkg::mbe_event_t e, e2;
		logic [3:0] m_ln, m_rg, el, er;
		logic [3:0] a_ln [2];
		logic [2:0] m_pt;
		logic       amb;
		int         n;
		m_ln = '0;
		m_rg = '0;
		a_ln = '{4'h0, 4'h0};
		repeat (6) @(posedge sys_clk);
		#1 rstn = 1'b1;
		for (int i = 0; i < mbe_pkg::NUM_INST; i++) chk("capt.valid", 0, capt[i].valid);
		chk("regs", 0, {controller_ctrl_status, dsr} | {ereg, acsr0} | {acsr1, nmi, irq});
		$display("test reset done");
		rsel_wr    = 1'b1;
		rsel_wdata = 24'($random(seed));
		tick;
		rsel_wr = 1'b0;
		chk("rsel", rsel_wdata, rsel);
		auto_en = 1'b1;
		// Every instance meets every error kind; the firmware pace is picked at random
		for (int i = 0; i < mbe_pkg::NUM_INST; i++) begin
			for (int k = 1; k < 4; k++) begin
				e       = rnd(k);
				nmi_sel = 1'($random(seed));
				slow    = 1'($random(seed));
				// Group A first sees a refresh address parity error, the others an access one
				if (k == 2) e.refresh = (i == 1);
				el  = (k == 3) ? e.lanes : 4'h0;
				er  = (i == 0) ? e.region : (i >= 3 && k == 1) ? rsel[15:12] : rsel[11:8];
				amb = (i != 0) && (k >= 2) && !e.refresh;
				if (i == 0) m_ln = el;
				if (i == 0 && k >= 2) m_rg = e.region;
				if (i == 1 || i == 2) a_ln[i-1] = el;
				m_pt = e.port;
				err_ev[i] = e;
				tick;
				err_ev[i] = '0;
				chk("capt.valid", 1, capt[i].valid);
				chk("capt.kind", k, capt[i].kind);
				chk("capt.addr", e.addr, capt[i].addr);
				chk("capt.data", e.data, capt[i].data);
				chk("capt.lanes", el, capt[i].lanes);
				chk("capt.region_mem", er, capt[i].region_mem);
				chk("capt.region_amb", amb, capt[i].region_amb);
				if (amb) chk("capt.region_reg", rsel[23:20], capt[i].region_reg);
				chk("ctrl_status", {3'h0, m_pt, 6'h00, m_ln}, controller_ctrl_status);
				chk("error_region", m_rg, ereg);
				chk("a_csr", {a_ln[1], a_ln[0]}, {acsr1[3:0], acsr0[3:0]});
				tick;
				chk("nmi irq", {nmi_sel, !nmi_sel}, {nmi, irq});
				tick;
				chk("diag_status", nmi_sel ? 16'h4000 : 16'h0000, dsr);
				e2 = rnd(k);
				err_ev[i] = e2;
				tick;
				err_ev[i] = '0;
				chk("held data", e.data, capt[i].data);
				chk("held addr", e.addr, capt[i].addr);
				n = 0;
				while (capt[i].valid !== 1'b0 && n < 40) begin
					tick;
					n++;
				end
				if (n >= 40) begin
					err_total++;
					finish_test();
				end
				tick;
				chk("lines idle", 0, {nmi, irq});
			end
		end
		$display("test capture done");
		// Two port events at once, lower index kept; then release and new error together
		auto_en   = 1'b0;
		err_ev[1] = rnd(3);
		err_ev[4] = rnd(1);
		m_pt      = err_ev[1].port;
		tick;
		chk("port tie", m_pt, controller_ctrl_status[12:10]);
		err_ev[1] = rnd(3);
		err_ev[4] = '0;
		e         = err_ev[1];
		tb_clr[1] = 1'b1;
		tick;
		err_ev = '0;
		tb_clr = '0;
		chk("clr+event data", e.data, capt[1].data);
		chk("a_csr", e.lanes, acsr0[3:0]);
		chk("port held", m_pt, controller_ctrl_status[12:10]);
		tb_clr = 5'b10010;
		tick;
		tb_clr = '0;
		chk("released", 0, {capt[1].valid, capt[4].valid});
		$display("test release done");
		finish_test();
	end
endmodule : mbe_memory_bus_controller_tb
`default_nettype wire

// ===== mbe_pkg.sv
// Shared constants and carrier types for the memory bus error capture block
`default_nettype none
package mbe_pkg;
	// ========================================
	// Instances
	localparam int NUM_INST = 5;
	localparam int INST_MST = 0;
	localparam int INST_A0  = 1;
	localparam int INST_A1  = 2;
	localparam int INST_B0  = 3;
	localparam int INST_B1  = 4;
	// ========================================
	// Widths
	localparam int ADDR_W = 28;
	localparam int DATA_W = 32;
	localparam int REG_W  = 16;
	localparam int RSEL_W = 24;
	localparam int RGN_W  = 4;
	localparam int LANE_W = 4;
	localparam int PORT_W = 3;
	// ========================================
	// Field positions
	localparam int CSR_LANE_LO  = 0;
	localparam int CSR_PORT_LO  = 10;
	localparam int DSR_NMI_BIT  = 14;
	localparam int ERR_RGN_LO   = 0;
	localparam int RSEL_AMEM_LO = 8;
	localparam int RSEL_BMEM_LO = 12;
	localparam int RSEL_REG_LO  = 20;
	// ========================================
	// Reset values
	localparam logic [REG_W-1:0]  CSR_RST  = 16'h0000;
	localparam logic [REG_W-1:0]  DSR_RST  = 16'h0000;
	localparam logic [REG_W-1:0]  ERR_RST  = 16'h0000;
	localparam logic [RSEL_W-1:0] RSEL_RST = 24'h00_0000;
	// ========================================
	// Types
	typedef enum logic [1:0] {
		MBE_NONE,
		MBE_NXM,
		MBE_APAR,
		MBE_WPAR
	} mbe_kind_t;

	typedef struct packed {
		logic              valid;
		mbe_kind_t         kind;
		logic              refresh;
		logic [ADDR_W-1:0] addr;
		logic [RGN_W-1:0]  region;
		logic [DATA_W-1:0] data;
		logic [LANE_W-1:0] lanes;
		logic              port_vld;
		logic [PORT_W-1:0] port;
	} mbe_event_t;

	typedef struct packed {
		logic              valid;
		mbe_kind_t         kind;
		logic              refresh;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [LANE_W-1:0] lanes;
		logic [RGN_W-1:0]  region_mem;
		logic [RGN_W-1:0]  region_reg;
		logic              region_amb;
	} mbe_capt_t;

	// ========================================
	// An error is taken when nothing is held, or when the hold is released now
	function automatic logic accepts(input mbe_event_t ev, input logic held, input logic clr);
		accepts = ev.valid && (ev.kind != MBE_NONE) && (!held || clr);
	endfunction : accepts
endpackage : mbe_pkg
`default_nettype wire

// ===== mbe_report.sv
// Reporting path: non-maskable or ordinary interrupt and the path flag
`default_nettype none
module mbe_report (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	// Events
	input  wire logic any_accept,
	input  wire logic any_held,
	input  wire logic cfg_nmi_sel,
	// Report
	output logic      nmi_r,
	output logic      irq_r,
	output logic      path_nmi_r
);
	logic nmi_nxt;
	logic irq_nxt;
	logic path_nmi_nxt;

	always_comb begin
		nmi_nxt      = nmi_r;
		irq_nxt      = irq_r;
		path_nmi_nxt = path_nmi_r;
		if (any_accept) begin
			nmi_nxt      = nmi_r | cfg_nmi_sel; // R4
			irq_nxt      = irq_r | !cfg_nmi_sel; // R4
			path_nmi_nxt = cfg_nmi_sel; // R4
		end else if (!any_held) begin
			// Lines drop once firmware has released every capture
			nmi_nxt = 1'b0;
			irq_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			nmi_r      <= 1'b0;
			irq_r      <= 1'b0;
			path_nmi_r <= 1'b0;
		end else begin
			nmi_r      <= nmi_nxt;
			irq_r      <= irq_nxt;
			path_nmi_r <= path_nmi_nxt;
		end
	end
endmodule : mbe_report
`default_nettype wire
